// File: lct_defs.svh
// Constants of the logic capture trigger front end
`ifndef LCT_DEFS_SVH
`define LCT_DEFS_SVH

// ************************************************************
// Channel layout
// ************************************************************
`define LCT_NUM_CH 8
`define LCT_ANA_CH 4
`define LCT_ANA_LSB 0
`define LCT_DIG_LSB 4

// ************************************************************
// Capture memory and delay
// ************************************************************
`define LCT_DEPTH 1024
`define LCT_DELAY_W 16
`define LCT_DIV_W 8

// ************************************************************
// Reset values
// ************************************************************
`define LCT_RST_WORD 8'h00
`define LCT_RST_DIV 8'h00

`endif

// File: lct_pkg.sv
// Types shared by the logic capture trigger front end
package lct_pkg;

   // Word compare: value plus care mask, a clear care bit is don't-care
   typedef struct packed {
      logic [7:0] value;
      logic [7:0] care;
   } lct_match_type;

   // Acquisition setup, taken into the link domain at arm
   typedef struct packed {
      logic [7:0] polarity;    // 1 = invert channel
      logic [7:0] latch_mode;  // 1 = latch, 0 = sample
      logic analog_mode;       // channels 0-3 carry conversions
      logic analog_trig;       // trigger on conversion msb
      logic analog_true;       // msb to 1, else msb to 0
      logic sync_clock;        // 1 = clock from circuit under test
      logic [7:0] async_div;   // internal strobe every div+1 cycles
      logic [15:0] delay;      // words stored after trigger
      lct_match_type enable_word;
      lct_match_type trigger_word;
   } lct_cfg_type;

   typedef enum logic [4:0] {
      LCT_IDLE      = 5'h01,
      LCT_WAIT_EN   = 5'h02,
      LCT_WAIT_TRIG = 5'h04,
      LCT_DELAY     = 5'h08,
      LCT_FROZEN    = 5'h10
   } lct_state_type;

endpackage

// File: lct_word_match.sv
// Masked word comparator for enable and trigger events
`timescale 1ns/1ps
module lct_word_match
   import lct_pkg::*;
(
   input wire logic sys_clk,        // link domain clock
   input wire logic srst,           // link domain reset
   input wire logic [7:0] word,     // stream word
   input lct_match_type pattern,    // value and care mask
   output logic hit                 // word matches pattern
);
   assign hit = ((word ^ pattern.value) & pattern.care) == 8'h00;

   a_match_exact: assert property (@(posedge sys_clk) disable iff (srst)
      hit == (((word & pattern.care) == (pattern.value & pattern.care))))
      else $error("mask compare wrong");
endmodule // lct_word_match

// File: lct_chan_capture.sv
// One probe channel: sample or glitch latch capture
`timescale 1ns/1ps
module lct_chan_capture (
   input wire logic clk,        // acquisition clock
   input wire logic rst,        // acquisition reset
   input wire logic strobe,     // active acquisition edge
   input wire logic level,      // comparator level, polarity applied
   input wire logic latch_en,   // 1 = latch mode
   output logic out             // captured channel
);
   logic seen_hi;
   logic seen_lo;
   wire glitch = level ? seen_lo : seen_hi;
   wire next_out = (latch_en && glitch) ? ~level : level;

   // Both polarities are remembered between edges
   always_ff @(posedge clk) begin
      if (rst || strobe) begin
         seen_hi <= 1'b0;
         seen_lo <= 1'b0;
      end else begin
         seen_hi <= seen_hi | level;
         seen_lo <= seen_lo | ~level;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out <= 1'b0;
      end else if (strobe) begin
         out <= next_out;
      end
   end

   a_chan_hold: assert property (@(posedge clk) disable iff (rst)
      !strobe |=> $stable(out)) else $error("output moved off edge");
   a_chan_clean: assert property (@(posedge clk) disable iff (rst)
      strobe && !glitch |=> out == $past(level)) else $error("clean edge differs");
   a_chan_glitch: assert property (@(posedge clk) disable iff (rst)
      strobe && latch_en && glitch |=> out != $past(level)) else $error("glitch lost");
endmodule // lct_chan_capture

// File: lct_frontend.sv
// Acquisition front end: capture, enable/trigger, freeze memory
`timescale 1ns/1ps
`include "lct_defs.svh"
module lct_frontend
   import lct_pkg::*;
#(
   parameter int DEPTH = `LCT_DEPTH,
   parameter int AW = $clog2(`LCT_DEPTH)
) (
   input wire logic sys_clk,           // control clock, 125 MHz
   input wire logic srst,              // synchronous reset, high
   input wire logic acq_clk,           // fast internal acquisition clock
   input wire logic arm,               // pulse: start a recording
   input lct_cfg_type cfg,             // setup, hold stable around arm
   input wire logic [7:0] probe_in,    // comparator outputs, async pins
   input wire logic dut_clk_in,        // clock of circuit under test
   input wire logic [3:0] adc_data,    // converter word, acq_clk domain
   input wire logic [AW-1:0] rd_addr,  // readout address
   output logic [7:0] rd_data,         // readout word, one cycle late
   output logic [AW-1:0] start_addr,   // oldest word of frozen record
   output logic ready                  // recording frozen
);
   // ************************************************************
   // Control domain: arm toggle and reset into link domain
   // ************************************************************
   logic arm_tgl;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         arm_tgl <= 1'b0;
      end else if (arm) begin
         arm_tgl <= ~arm_tgl;
      end
   end

   logic rst_m;
   logic acq_rst;
   always_ff @(posedge acq_clk) begin
      rst_m <= srst;
      acq_rst <= rst_m;
   end

   logic arm_m;
   logic arm_s;
   logic arm_d;
   always_ff @(posedge acq_clk) begin
      if (acq_rst) begin
         arm_m <= 1'b0;
         arm_s <= 1'b0;
         arm_d <= 1'b0;
      end else begin
         arm_m <= arm_tgl;
         arm_s <= arm_m;
         arm_d <= arm_s;
      end
   end
   wire arm_evt = arm_s ^ arm_d;

   // Setup is taken once per arm; sys side holds it stable meanwhile
   lct_cfg_type cfg_q;
   always_ff @(posedge acq_clk) begin
      if (acq_rst) begin
         cfg_q <= '0;
      end else if (arm_evt) begin
         cfg_q <= cfg;
      end
   end

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [7:0] probe_m;
   logic [7:0] probe_s;
   logic dclk_m;
   logic dclk_s;
   logic dclk_d;
   always_ff @(posedge acq_clk) begin
      probe_m <= probe_in;
      probe_s <= probe_m;
      dclk_m <= dut_clk_in;
      dclk_s <= dclk_m;
   end
   always_ff @(posedge acq_clk) begin
      if (acq_rst) begin
         dclk_d <= 1'b0;
      end else begin
         dclk_d <= dclk_s;
      end
   end

   // ************************************************************
   // Acquisition strobe
   // ************************************************************
   logic [`LCT_DIV_W-1:0] div_cnt;
   wire div_tick = (div_cnt == cfg_q.async_div);
   always_ff @(posedge acq_clk) begin
      if (acq_rst || div_tick) begin
         div_cnt <= `LCT_RST_DIV;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   wire dut_edge = dclk_s && !dclk_d;
   wire strobe = cfg_q.sync_clock ? dut_edge : div_tick;

   // ************************************************************
   // Channel capture
   // ************************************************************
   wire [7:0] level = probe_s ^ cfg_q.polarity;
   logic [7:0] chan;
   genvar gi;
   generate
      for (gi = 0; gi < `LCT_NUM_CH; gi++) begin : g_ch
         lct_chan_capture u_ch (
            .clk(acq_clk),
            .rst(acq_rst),
            .strobe(strobe),
            .level(level[gi]),
            .latch_en(cfg_q.latch_mode[gi]),
            .out(chan[gi])
         );
      end
   endgenerate

   // Conversion registered on the same edge as the channels
   logic [3:0] adc_q;
   logic word_vld;
   always_ff @(posedge acq_clk) begin
      if (acq_rst) begin
         adc_q <= 4'h0;
         word_vld <= 1'b0;
      end else begin
         word_vld <= strobe;
         if (strobe) begin
            adc_q <= adc_data;
         end
      end
   end

   // Low nibble swapped for the conversion in analog mode
   wire [7:0] word = cfg_q.analog_mode ? {chan[7:4], adc_q} : chan;
   wire msb = adc_q[3];

   // ************************************************************
   // Event detection
   // ************************************************************
   logic en_hit;
   logic dig_hit;
   lct_word_match u_en (
      .sys_clk(acq_clk),
      .srst(acq_rst),
      .word(word),
      .pattern(cfg_q.enable_word),
      .hit(en_hit)
   );
   lct_word_match u_trig (
      .sys_clk(acq_clk),
      .srst(acq_rst),
      .word(word),
      .pattern(cfg_q.trigger_word),
      .hit(dig_hit)
   );

   // Msb history is per stored word, so first word never fires
   logic msb_prev;
   logic msb_known;
   always_ff @(posedge acq_clk) begin
      if (acq_rst || arm_evt) begin
         msb_prev <= 1'b0;
         msb_known <= 1'b0;
      end else if (word_vld) begin
         msb_prev <= msb;
         msb_known <= 1'b1;
      end
   end
   // Mid-range crossing: rising slope sets msb, falling clears it
   wire msb_rise = msb_known && !msb_prev && msb;
   wire msb_fall = msb_known && msb_prev && !msb;
   wire ana_hit = cfg_q.analog_true ? msb_rise : msb_fall;
   wire trig_hit = cfg_q.analog_trig ? ana_hit : dig_hit;

   // ************************************************************
   // Freeze sequencer
   // ************************************************************
   lct_state_type state;
   lct_state_type next_state;
   logic [`LCT_DELAY_W-1:0] dly_cnt;
   wire dly_zero = (cfg_q.delay == 16'h0000);
   wire dly_done = (dly_cnt == 16'h0001);

   always_comb begin
      next_state = state;
      unique case (state)
         LCT_IDLE: begin
            next_state = state;
         end
         LCT_WAIT_EN: begin
            if (word_vld && en_hit) begin
               next_state = LCT_WAIT_TRIG;
            end
         end
         LCT_WAIT_TRIG: begin
            if (word_vld && trig_hit) begin
               next_state = dly_zero ? LCT_FROZEN : LCT_DELAY;
            end
         end
         LCT_DELAY: begin
            if (word_vld && dly_done) begin
               next_state = LCT_FROZEN;
            end
         end
         LCT_FROZEN: begin
            next_state = state;
         end
         default: begin
            next_state = LCT_IDLE;
         end
      endcase
      if (arm_evt) begin
         next_state = LCT_WAIT_EN;
      end
   end

   always_ff @(posedge acq_clk) begin
      if (acq_rst) begin
         state <= LCT_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge acq_clk) begin
      if (acq_rst) begin
         dly_cnt <= 16'h0000;
      end else if (state == LCT_WAIT_TRIG) begin
         dly_cnt <= cfg_q.delay;
      end else if (state == LCT_DELAY && word_vld) begin
         dly_cnt <= dly_cnt - 16'h0001;
      end
   end

   // ************************************************************
   // Capture memory
   // ************************************************************
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   wire recording = (state == LCT_WAIT_EN) || (state == LCT_WAIT_TRIG) || (state == LCT_DELAY);
   wire mem_we = recording && word_vld;

   always_ff @(posedge acq_clk) begin
      if (mem_we) begin
         mem[wr_ptr] <= word;
      end
   end
   always_ff @(posedge acq_clk) begin
      if (acq_rst || arm_evt) begin
         wr_ptr <= '0;
      end else if (mem_we) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // Memory is static once frozen, so the other port may read freely
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_data <= `LCT_RST_WORD;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

   // ************************************************************
   // Ready back to control domain
   // ************************************************************
   wire frozen = (state == LCT_FROZEN);
   logic rdy_m;
   logic rdy_s;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdy_m <= 1'b0;
         rdy_s <= 1'b0;
         ready <= 1'b0;
         start_addr <= '0;
      end else begin
         rdy_m <= frozen;
         rdy_s <= rdy_m;
         ready <= rdy_s;
         if (rdy_s && !ready) begin
            start_addr <= wr_ptr; // stable while frozen
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_frozen_nowrite: assert property (@(posedge acq_clk) disable iff (acq_rst)
      frozen && !arm_evt |=> $stable(wr_ptr)) else $error("write after freeze");
   a_trig_after_en: assert property (@(posedge acq_clk) disable iff (acq_rst)
      state == LCT_WAIT_EN |=> state inside {LCT_WAIT_EN, LCT_WAIT_TRIG}) else $error("skipped enable");
   a_zero_delay: assert property (@(posedge acq_clk) disable iff (acq_rst)
      state == LCT_WAIT_TRIG && word_vld && trig_hit && dly_zero && !arm_evt |=> frozen)
      else $error("no freeze on trigger");
   a_ana_fire: assert property (@(posedge acq_clk) disable iff (acq_rst)
      state == LCT_WAIT_TRIG && word_vld && cfg_q.analog_trig && !arm_evt
      && (cfg_q.analog_true ? (msb_known && !msb_prev && msb) : (msb_known && msb_prev && !msb))
      |=> state != LCT_WAIT_TRIG) else $error("analog trigger missed");
   a_ana_quiet: assert property (@(posedge acq_clk) disable iff (acq_rst)
      state == LCT_WAIT_TRIG && cfg_q.analog_trig && word_vld && msb == msb_prev && !arm_evt
      |=> state == LCT_WAIT_TRIG) else $error("analog false fire");
   a_wrap_step: assert property (@(posedge acq_clk) disable iff (acq_rst)
      mem_we && !arm_evt |=> wr_ptr == $past(wr_ptr) + 1'b1) else $error("pointer step wrong");
   a_ana_word: assert property (@(posedge acq_clk) disable iff (acq_rst)
      cfg_q.analog_mode |-> word[3:0] == adc_q && word[7:4] == chan[7:4]) else $error("analog mix wrong");
   a_ready_late: assert property (@(posedge acq_clk) disable iff (acq_rst)
      !frozen |=> !frozen || $past(state) != LCT_IDLE) else $error("idle froze");
   a_ready_follow: assert property (@(posedge sys_clk) disable iff (srst)
      rdy_s |=> ready) else $error("ready not raised");
endmodule // lct_frontend

// File: lct_dut_model.sv
// Model of the circuit under test that drives the probes
`timescale 1ns/1ps
module lct_dut_model (
   input wire logic acq_clk,            // acquisition clock, paces the converter
   input wire logic srst,               // restarts the pattern count
   input wire logic [7:0] data_mask,    // probes that carry the count
   input wire logic [7:0] base,         // fixed probe levels
   input wire logic [7:0] glitch_mask,  // probes pulsed once per cycle
   output logic dut_clk,                // free running clock of the circuit
   output logic [7:0] probe,            // probe pins
   output logic [3:0] adc               // converter word, sawtooth ramp
);
   logic [7:0] cnt;
   logic [7:0] glitch;

   initial begin
      dut_clk = 1'b0;
      cnt = 8'h00;
      glitch = 8'h00;
      adc = 4'h0;
      forever #192 dut_clk = ~dut_clk;
   end

   // Data moves on the falling edge, so it is settled well before the rising one
   always @(negedge dut_clk) begin
      cnt <= srst ? 8'h00 : cnt + 8'h01;
      #30 glitch = glitch_mask;
      #60 glitch = 8'h00;
   end

   // Ramp msb rises at mid-range, falls at the wrap
   always @(posedge acq_clk) begin
      adc <= cnt[3:0];
   end

   assign probe = ((cnt & data_mask) | base) ^ glitch;
endmodule // lct_dut_model

// File: lct_testbench.sv
// Self-checking bench of the capture front end
`timescale 1ns/1ps
module testbench
   import lct_pkg::*;
;
   localparam int DEPTH = 16;
   localparam int AW = 4;
   logic sys_clk, acq_clk, srst, arm, ready, dut_clk_in;
   lct_cfg_type cfg;
   logic [7:0] probe_in, rd_data, data_mask, base, glitch_mask, pol;
   logic [3:0] adc_data;
   logic [AW-1:0] rd_addr, start_addr, sa;
   logic rd_req;
   logic rd_req_d = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] exp_w[16];
   logic [15:0] seed;
   int mismatches, n_tests;

   lct_frontend #(.DEPTH(DEPTH), .AW(AW)) lct_frontend_i (
      .sys_clk(sys_clk), .srst(srst), .acq_clk(acq_clk), .arm(arm), .cfg(cfg), .probe_in(probe_in),
      .dut_clk_in(dut_clk_in), .adc_data(adc_data), .rd_addr(rd_addr), .rd_data(rd_data),
      .start_addr(start_addr), .ready(ready));

   lct_dut_model lct_dut_model_i (
      .acq_clk(acq_clk), .srst(srst), .data_mask(data_mask), .base(base), .glitch_mask(glitch_mask),
      .dut_clk(dut_clk_in), .probe(probe_in), .adc(adc_data));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Odd offset keeps the two clocks out of step
   initial begin
      acq_clk = 1'b0;
      #3.7;
      forever #24 acq_clk = ~acq_clk;
   end

   // ************************************************************
   // Checking and reporting
   // ************************************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Read data lands one edge after the address is taken
   always @(posedge sys_clk) begin
      rd_req_d <= rd_req;
      if (rd_req_d) begin
         check("rd_data", rd_data, exp_q.pop_front());
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Arm, wait for the freeze, then read the newest n words back
   task automatic record(input lct_cfg_type c, input int n);
      int t;
      repeat (100) @(posedge sys_clk);
      cfg <= c;
      arm <= 1'b1;
      @(posedge sys_clk);
      arm <= 1'b0;
      t = 0;
      while (ready !== 1'b0 && t < 200) begin
         @(posedge sys_clk);
         t++;
      end
      check("ready after arm", ready, 1'b0);
      t = 0;
      while (ready !== 1'b1 && t < 9000) begin
         @(posedge sys_clk);
         t++;
      end
      check("ready", ready, 1'b1);
      sa = start_addr;
      for (int k = 0; k < n; k++) begin
         @(posedge sys_clk);
         rd_addr <= AW'(sa + AW'(DEPTH - 1 - k));
         rd_req <= 1'b1;
         exp_q.push_back(exp_w[k]);
      end
      @(posedge sys_clk);
      rd_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   initial begin
      repeat (30000) @(posedge sys_clk);
      mismatches++;
      close_out();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      lct_cfg_type c;
      logic [7:0] last;
      srst = 1'b1;
      arm = 1'b0;
      cfg = '0;
      rd_addr = '0;
      rd_req = 1'b0;
      data_mask = 8'h00;
      base = 8'h00;
      glitch_mask = 8'h00;
      seed = 16'd9503;
      mismatches = 0;
      n_tests = 0;
      repeat (12) @(posedge sys_clk);
      // Acquisition side needs four of its own edges in reset
      repeat (4) @(posedge acq_clk);
      @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("ready reset", ready, 1'b0);
      check("start_addr reset", start_addr, 16'h0000);
      check("rd_data reset", rd_data, 16'h0000);
      // Digital: trigger nibble also passes before the enable word
      seed = lfsr(seed);
      pol = seed[7:0];
      data_mask <= 8'hFF;
      c = '0;
      c.polarity = pol;
      c.sync_clock = 1'b1;
      c.delay = {14'h0000, seed[9:8]};
      c.enable_word = '{pol ^ 8'h20, 8'hFF};
      c.trigger_word = '{pol ^ 8'h05, 8'h0F};
      for (int k = 0; k < 16; k++) begin
         exp_w[k] = 8'(8'h25 + seed[9:8] - k) ^ pol;
      end
      record(c, 16);
      // Latch on some channels, glitches of both senses
      c.latch_mode = 8'hB0;
      c.delay = '0;
      c.enable_word = '{8'h03 ^ pol, 8'h0F};
      c.trigger_word = '{8'h09 ^ pol, 8'h0F};
      data_mask <= 8'h0F;
      base <= 8'h20;
      glitch_mask <= 8'hE0;
      for (int k = 0; k < 7; k++) begin
         exp_w[k] = (8'(8'h09 - k) & 8'h0F | 8'h80) ^ pol;
      end
      record(c, 7);
      // Analog conversions on the low channels, true then false
      for (int tr = 1; tr >= 0; tr--) begin
         seed = lfsr(seed);
         c = '0;
         c.polarity = pol;
         c.sync_clock = 1'b1;
         c.analog_mode = 1'b1;
         c.analog_trig = 1'b1;
         c.analog_true = tr[0];
         c.enable_word = '{8'h02, 8'h0F};
         data_mask <= 8'h00;
         base <= seed[7:0];
         glitch_mask <= 8'h00;
         last = tr[0] ? 8'h08 : 8'h00;
         for (int k = 0; k < 7; k++) begin
            exp_w[k] = {seed[7:4] ^ pol[7:4], 4'(last - k)};
         end
         record(c, 7);
      end
      // Internal clock, steady data: latch and sample agree
      c = '0;
      c.polarity = pol;
      c.latch_mode = seed[15:8];
      c.async_div = 8'h07;
      c.delay = 16'h0003;
      for (int k = 0; k < 4; k++) begin
         exp_w[k] = seed[7:0] ^ pol;
      end
      record(c, 4);
      close_out();
   end
endmodule // testbench
